// ---- rtl/lpd_defs.vh ----
// constants for the link quality, power control and disassociation element codec
`ifndef LPD_DEFS_VH
`define LPD_DEFS_VH
`define LPD_ID_LQ          8'h01
`define LPD_ID_PC          8'h02
`define LPD_ID_DA          8'h03
`define LPD_LQ_LEN         8'h03
`define LPD_PC_ENTRY_LEN   8'h03
`define LPD_DA_ENTRY_LEN   8'h03
`define LPD_PWR_MAX_CODE   8'h63
`define LPD_BCAST_ADDR     16'hFFFF
`define LPD_UNASSOC_ADDR   16'h0000
`define LPD_MCAST_BIT      15
`define LPD_PWR_RESET      8'h00
`define LPD_REASON_NORES   8'h00
`define LPD_REASON_COEX    8'h02
`define LPD_REG_CTRL       4'h0
`define LPD_REG_STATUS     4'h1
`define LPD_REG_MASK       4'h2
`define LPD_REG_OWNADDR    4'h3
`define LPD_REG_MCAST      4'h4
`define LPD_REG_PWR        4'h5
`define LPD_REG_NEWPWR     4'h6
`define LPD_REG_LQ         4'h7
`define LPD_REG_REASON     4'h8
`define LPD_REG_TXLQ       4'h9
`define LPD_REG_TXPC       4'hA
`define LPD_REG_TXDA       4'hB
`define LPD_ST_PWR         0
`define LPD_ST_NEWPWR      1
`define LPD_ST_LQ          2
`define LPD_ST_DISASSOC    3
`define LPD_ST_BADLEN      4
`define LPD_ST_TXDONE      5
`define LPD_ST_W           6
`endif

// ---- rtl/lpd_codec.v ----
// element codec: parses and builds quality, power and disassociation elements
`timescale 1ns/1ps
`default_nettype none
`include "lpd_defs.vh"
// How it works
// - quality element: length 3, estimate, address
// - quality address names measured signal source
// - power element: count, entries, length 1+3N
// - power entry: 16-bit address, 8-bit code
// - addressed device stores and uses power
// - broadcast entry updates every device
// - multicast entry updates group members
// - unassociated entry kept for later association
// - power code is mW minus one, 0-99
// - disassociation entries: address, reason; length 3N
// - named device releases slots, ends connections
// - reason code informative; 0,2 defined
module lpd_codec
(
  input  wire        core_clk,
  input  wire        rst,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  output wire        irq,
  // received element byte stream
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        rx_start,
  // transmitted element byte stream
  output reg         tx_valid,
  output reg  [7:0]  tx_data,
  output reg         tx_last,
  input  wire        tx_ready,
  // effects on the rest of the mac
  output reg  [7:0]  tx_power_code,
  output reg         release_slots,
  output reg         end_connections
);

  // ********************************************
  // parser state
  // ********************************************
  localparam [5:0] P_IDLE = 6'h01;
  localparam [5:0] P_LEN  = 6'h02;
  localparam [5:0] P_CNT  = 6'h04;
  localparam [5:0] P_BODY = 6'h08;
  localparam [5:0] P_SKIP = 6'h10;
  localparam [5:0] P_ID   = 6'h20;
  reg [5:0]  pst_q;
  reg [7:0]  id_q;
  reg [7:0]  len_q;
  reg [7:0]  left_q;
  reg [1:0]  pos_q;
  reg [7:0]  addr_q;
  reg [7:0]  b0_q;
  reg [15:0] own_addr_q;
  reg [15:0] mcast_q;
  reg [7:0]  new_pwr_q;
  reg [7:0]  lq_q;
  reg [15:0] lq_src_q;
  reg [7:0]  reason_q;
  reg [`LPD_ST_W-1:0] status_q;
  reg [`LPD_ST_W-1:0] mask_q;
  reg [`LPD_ST_W-1:0] ev_q;
  reg [15:0] txlq_q;
  reg [15:0] txpc_q;
  reg [15:0] txda_q;
  reg [7:0]  txlqv_q;
  reg [7:0]  txpcv_q;
  reg        rel_pend;

  wire [7:0] len_pc = `LPD_PC_ENTRY_LEN * rx_data + 8'h01;
  // addresses arrive low byte first, so the second body byte is the high byte
  wire [15:0] ent_addr2 = {b0_q, addr_q};
  wire        is_pc = (id_q == `LPD_ID_PC);
  wire        is_da = (id_q == `LPD_ID_DA);
  wire        is_lq = (id_q == `LPD_ID_LQ);
  wire        bcast = (ent_addr2 == `LPD_BCAST_ADDR);
  wire        unas  = (ent_addr2 == `LPD_UNASSOC_ADDR);
  wire        mcast = ent_addr2[`LPD_MCAST_BIT] && !bcast && (ent_addr2 == mcast_q);
  wire        mine  = (ent_addr2 == own_addr_q);
  wire        code_ok = (rx_data <= `LPD_PWR_MAX_CODE);

  // ********************************************
  // receive parser and effects
  // ********************************************
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      pst_q           <= P_IDLE;
      id_q            <= 8'h00;
      len_q           <= 8'h00;
      left_q          <= 8'h00;
      pos_q           <= 2'h0;
      addr_q          <= 8'h00;
      b0_q            <= 8'h00;
      new_pwr_q       <= `LPD_PWR_RESET;
      tx_power_code   <= `LPD_PWR_RESET;
      lq_q            <= 8'h00;
      lq_src_q        <= 16'h0000;
      reason_q        <= 8'h00;
      release_slots   <= 1'b0;
      end_connections <= 1'b0;
      rel_pend        <= 1'b0;
      ev_q            <= {`LPD_ST_W{1'b0}};
    end
    else
    begin
      ev_q            <= {`LPD_ST_W{1'b0}};
      release_slots   <= 1'b0;
      end_connections <= 1'b0;
      if (rx_start)
        pst_q <= P_ID;
      else if (rx_valid)
      begin
        case (pst_q)
          P_ID:
          begin
            id_q  <= rx_data;
            pst_q <= P_LEN;
          end
          P_LEN:
          begin
            len_q    <= rx_data;
            left_q   <= rx_data;
            pos_q    <= 2'h0;
            rel_pend <= 1'b0;
            if (rx_data == 8'h00)
              pst_q <= P_ID;
            else if ((is_lq && rx_data != `LPD_LQ_LEN) ||
                     (is_da && (rx_data % `LPD_DA_ENTRY_LEN) != 8'h00))
            begin
              ev_q[`LPD_ST_BADLEN] <= 1'b1;
              pst_q <= P_SKIP;
            end
            else if (is_pc)
              pst_q <= P_CNT;
            else if (is_lq || is_da)
              pst_q <= P_BODY;
            else
              pst_q <= P_SKIP; // unknown id
          end
          P_CNT:
          begin
            left_q <= left_q - 8'h01;
            ev_q[`LPD_ST_BADLEN] <= (len_q != len_pc);
            pst_q  <= (left_q == 8'h01) ? P_ID : ((len_q != len_pc) ? P_SKIP : P_BODY);
          end
          P_BODY:
          begin
            left_q <= left_q - 8'h01;
            pos_q  <= (pos_q == 2'h2) ? 2'h0 : pos_q + 2'h1;
            if (pos_q == 2'h0)
              addr_q <= rx_data;
            if (pos_q == 2'h1)
              b0_q <= rx_data;
            if (pos_q == 2'h2)
            begin
              if (is_lq) // estimate first, then the signal source address
              begin
                lq_q     <= addr_q;
                lq_src_q <= {rx_data, b0_q};
                ev_q[`LPD_ST_LQ] <= 1'b1;
              end
              if (is_pc && code_ok)
              begin
                if (mine || bcast || mcast)
                begin
                  tx_power_code <= rx_data;
                  ev_q[`LPD_ST_PWR] <= 1'b1;
                end
                if (unas)
                begin
                  new_pwr_q <= rx_data;
                  ev_q[`LPD_ST_NEWPWR] <= 1'b1;
                end
              end
              if (is_da && mine)
              begin
                reason_q <= rx_data; // stored for software only
                rel_pend <= 1'b1;
              end
            end
            if (left_q == 8'h01)
            begin
              pst_q <= P_ID;
              if (is_da && (rel_pend || (pos_q == 2'h2 && mine)))
              begin
                release_slots   <= 1'b1;
                end_connections <= 1'b1;
                ev_q[`LPD_ST_DISASSOC] <= 1'b1;
              end
            end
          end
          P_SKIP:
          begin
            left_q <= left_q - 8'h01;
            if (left_q == 8'h01)
              pst_q <= P_ID;
          end
          default: pst_q <= P_IDLE;
        endcase
      end
    end
  end

  // ********************************************
  // element builder
  // ********************************************
  localparam [3:0] T_IDLE = 4'h1;
  localparam [3:0] T_LQ   = 4'h2;
  localparam [3:0] T_PC   = 4'h4;
  localparam [3:0] T_DA   = 4'h8;
  reg [3:0] tst_q;
  reg [2:0] tix_q;
  reg       txdone;
  reg [7:0] tbyte;
  reg       tlast;

  // one-entry elements only, which keeps the builder a fixed sequence
  always @*
  begin
    tbyte = 8'h00;
    tlast = (tst_q == T_PC) ? (tix_q == 3'h5) : (tix_q == 3'h4); // power element is one byte longer
    case (tst_q)
      T_LQ:
        case (tix_q)
          3'h0: tbyte = `LPD_ID_LQ;
          3'h1: tbyte = `LPD_LQ_LEN;
          3'h2: tbyte = txlqv_q;
          3'h3: tbyte = txlq_q[7:0];
          default: tbyte = txlq_q[15:8];
        endcase
      T_PC:
        case (tix_q)
          3'h0: tbyte = `LPD_ID_PC;
          3'h1: tbyte = `LPD_PC_ENTRY_LEN + 8'h01;
          3'h2: tbyte = 8'h01;
          3'h3: tbyte = txpc_q[7:0];
          3'h4: tbyte = txpc_q[15:8];
          default: tbyte = (txpcv_q > `LPD_PWR_MAX_CODE) ? `LPD_PWR_MAX_CODE : txpcv_q;
        endcase
      T_DA:
        case (tix_q)
          3'h0: tbyte = `LPD_ID_DA;
          3'h1: tbyte = `LPD_DA_ENTRY_LEN;
          3'h2: tbyte = txda_q[7:0];
          3'h3: tbyte = txda_q[15:8];
          default: tbyte = txlqv_q; // reason code shares the low control byte
        endcase
      default: tbyte = 8'h00;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      tst_q    <= T_IDLE;
      tix_q    <= 3'h0;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
      txdone   <= 1'b0;
    end
    else
    begin
      txdone <= 1'b0;
      if (tx_valid && !tx_ready)
        tst_q <= tst_q; // hold the byte until the sink takes it
      else if (tst_q == T_IDLE)
      begin
        tx_valid <= 1'b0;
        tx_last  <= 1'b0;
        tix_q    <= 3'h0;
        if (reg_wr && reg_addr == `LPD_REG_TXLQ)
          tst_q <= T_LQ;
        else if (reg_wr && reg_addr == `LPD_REG_TXPC)
          tst_q <= T_PC;
        else if (reg_wr && reg_addr == `LPD_REG_TXDA)
          tst_q <= T_DA;
      end
      else
      begin
        tx_valid <= 1'b1;
        tx_data  <= tbyte;
        tx_last  <= tlast;
        tix_q    <= tix_q + 3'h1;
        if (tlast)
        begin
          tst_q  <= T_IDLE;
          txdone <= 1'b1;
        end
      end
    end
  end

  // ********************************************
  // registers and interrupt
  // ********************************************
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      status_q   <= {`LPD_ST_W{1'b0}};
      mask_q     <= {`LPD_ST_W{1'b0}};
      own_addr_q <= 16'h0000;
      mcast_q    <= 16'h0000;
      txlq_q     <= 16'h0000;
      txpc_q     <= 16'h0000;
      txda_q     <= 16'h0000;
      txlqv_q    <= 8'h00;
      txpcv_q    <= 8'h00;
      reg_rdata  <= 16'h0000;
    end
    else
    begin
      // set wins over a same-cycle write-one clear
      status_q <= (status_q & ~((reg_wr && reg_addr == `LPD_REG_STATUS) ? reg_wdata[`LPD_ST_W-1:0]
                  : {`LPD_ST_W{1'b0}})) | ev_q | {txdone, {`LPD_ST_TXDONE{1'b0}}};
      if (reg_wr)
        case (reg_addr)
          `LPD_REG_MASK:    mask_q     <= reg_wdata[`LPD_ST_W-1:0];
          `LPD_REG_OWNADDR: own_addr_q <= reg_wdata;
          `LPD_REG_MCAST:   mcast_q    <= reg_wdata;
          `LPD_REG_TXLQ:    txlq_q     <= reg_wdata;
          `LPD_REG_TXPC:    txpc_q     <= reg_wdata;
          `LPD_REG_TXDA:    txda_q     <= reg_wdata;
          `LPD_REG_CTRL:
          begin
            txlqv_q <= reg_wdata[7:0];
            txpcv_q <= reg_wdata[15:8];
          end
          default: mask_q <= mask_q;
        endcase
      reg_rdata <= 16'h0000;
      if (reg_rd)
        case (reg_addr)
          `LPD_REG_CTRL:    reg_rdata <= {txpcv_q, txlqv_q};
          `LPD_REG_STATUS:  reg_rdata <= {{(16-`LPD_ST_W){1'b0}}, status_q};
          `LPD_REG_MASK:    reg_rdata <= {{(16-`LPD_ST_W){1'b0}}, mask_q};
          `LPD_REG_OWNADDR: reg_rdata <= own_addr_q;
          `LPD_REG_MCAST:   reg_rdata <= mcast_q;
          `LPD_REG_PWR:     reg_rdata <= {8'h00, tx_power_code};
          `LPD_REG_NEWPWR:  reg_rdata <= {8'h00, new_pwr_q};
          `LPD_REG_LQ:      reg_rdata <= {8'h00, lq_q};
          `LPD_REG_REASON:  reg_rdata <= {8'h00, reason_q};
          `LPD_REG_TXLQ:    reg_rdata <= lq_src_q;
          default:          reg_rdata <= 16'h0000;
        endcase
    end
  end

  assign irq = |(status_q & mask_q);

endmodule
`default_nettype wire

// ---- verif/lpd_codec_sva.sv ----
// port checker for the element codec
`timescale 1ns/1ps
`default_nettype none
`include "lpd_defs.vh"
module lpd_codec_sva
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        rx_valid,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_last,
  input wire logic        tx_ready,
  input wire logic [7:0]  tx_power_code,
  input wire logic        release_slots,
  input wire logic        end_connections
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ****
  // sent frame tracking
  // ****
  logic       acc;
  logic [2:0] idx_q;
  logic [7:0] id_q;
  assign acc = tx_valid && tx_ready;
  // byte index in the frame; the id is only trusted from byte one on
  always @(posedge core_clk)
  begin
    if (rst)
      idx_q <= 3'h0;
    else if (acc)
      idx_q <= tx_last ? 3'h0 : idx_q + 3'h1;
    if (acc && idx_q == 3'h0)
      id_q <= tx_data;
  end
  a_lq_frame:
  assert property (acc && id_q == `LPD_ID_LQ && idx_q != 3'h0 |->
    tx_last == (idx_q == 3'h4) && (idx_q != 3'h1 || tx_data == `LPD_LQ_LEN)) else $error("quality frame shape");
  a_pc_head:
  assert property (acc && id_q == `LPD_ID_PC && idx_q inside {3'h1, 3'h2} |->
    tx_data == (idx_q == 3'h1 ? 8'h04 : 8'h01)) else $error("power frame head");
  a_pc_entry:
  assert property (acc && id_q == `LPD_ID_PC && idx_q != 3'h0 |->
    tx_last == (idx_q == 3'h5) && (idx_q != 3'h5 || tx_data <= `LPD_PWR_MAX_CODE)) else $error("power entry");
  a_da_frame:
  assert property (acc && id_q == `LPD_ID_DA && idx_q != 3'h0 |->
    tx_last == (idx_q == 3'h4) && (idx_q != 3'h1 || tx_data == 8'h03)) else $error("release frame shape");
  a_tx_hold:
  assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("tx byte dropped while stalled");
  a_pwr_max:
  assert property (tx_power_code <= `LPD_PWR_MAX_CODE) else $error("power code reserved");
  a_pwr_cause:
  assert property (tx_power_code != $past(tx_power_code) |-> $past(rx_valid) || $past(rx_valid, 2) || $past(rst))
    else $error("power changed without rx");
  a_pulse_pair:
  assert property (release_slots == end_connections) else $error("release pulses apart");
  a_pulse_once:
  assert property (release_slots |=> !release_slots) else $error("release pulse too long");
  a_pulse_cause:
  assert property ($rose(release_slots) |-> $past(rx_valid) || $past(rx_valid, 2))
    else $error("release without rx");
  a_rd_zero:
  assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside slot");
endmodule
bind lpd_codec lpd_codec_sva chk (.core_clk(core_clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_valid(rx_valid), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
  .tx_power_code(tx_power_code), .release_slots(release_slots), .end_connections(end_connections));
`default_nettype wire

// ---- verif/lpd_peer_model.sv ----
// peer mac model: feeds element bytes and takes sent frames
`timescale 1ns/1ps
`default_nettype none
module lpd_peer_model
(
  input  wire logic       core_clk,
  input  wire logic       slow,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_start,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [8:0] got[$];
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_start = 1'b0;
    tx_ready = 1'b0;
  end
  // beacon payload bytes back to back; idle data is inverted so stale bytes never match
  task send(input logic st, input logic [7:0] q[$]);
    integer i;
    if (st)
    begin
      @(posedge core_clk);
      rx_start <= 1'b1;
    end
    for (i = 0; i < q.size(); i++)
    begin
      @(posedge core_clk);
      rx_start <= 1'b0;
      rx_valid <= 1'b1;
      rx_data <= q[i];
    end
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask
  // slow mode stalls every other cycle to exercise the hold
  always @(posedge core_clk)
  begin
    if (tx_valid && tx_ready)
      got.push_back({tx_last, tx_data});
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule
`default_nettype wire

// ---- verif/lpd_codec_tb.sv ----
// self-checking bench for the element codec
`timescale 1ns/1ps
`default_nettype none
`include "lpd_defs.vh"
module lpd_codec_tb;
  logic        core_clk, rst, reg_wr, reg_rd, slow, irq, rel, endc;
  logic        rx_valid, rx_start, tx_valid, tx_last, tx_ready;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [7:0]  rx_data, tx_data, pwr;
  integer      errors = 0, num_checks = 0, n_rel = 0, n_end = 0;
  lpd_codec uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_start(rx_start), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .tx_power_code(pwr), .release_slots(rel), .end_connections(endc));
  lpd_peer_model peer (.core_clk(core_clk), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_start(rx_start), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
  // ****
  // clock, counters and bus tasks
  // ****
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    n_rel += (!rst && rel === 1'b1);
    n_end += (!rst && endc === 1'b1);
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, e);
  endtask
  // waits for the whole frame, then compares bytes and the end marker
  task txchk(input logic [7:0] e[$]);
    integer i;
    for (i = 0; i < 400 && peer.got.size() < e.size(); i++)
      @(posedge core_clk);
    chk(16'(peer.got.size()), 16'(e.size()));
    for (i = 0; i < e.size() && i < peer.got.size(); i++)
      chk({7'h00, peer.got[i]}, {7'h00, i == e.size() - 1, e[i]});
    peer.got.delete();
  endtask
  // ****
  // scenarios
  // ****
  task t_reset;
    rchk(`LPD_REG_PWR, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rchk(`LPD_REG_STATUS, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
  endtask
  task t_power;
    static logic [15:0] a[7] = '{16'h1234, 16'hFFFF, 16'h8005, 16'h8006, 16'h4321, 16'h1234, 16'h0000};
    static logic [7:0] c[7] = '{8'h2A, 8'h10, 8'h11, 8'h12, 8'h13, 8'h64, 8'h20};
    static logic [7:0] e[7] = '{8'h2A, 8'h10, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11};
    integer i;
    wr(`LPD_REG_OWNADDR, 16'h1234);
    wr(`LPD_REG_MCAST, 16'h8005);
    for (i = 0; i < 7; i++)
    begin
      peer.send(1'b1, '{`LPD_ID_PC, 8'h04, 8'h01, a[i][7:0], a[i][15:8], c[i]});
      rchk(`LPD_REG_PWR, {8'h00, e[i]});
      chk({8'h00, pwr}, {8'h00, e[i]});
    end
    rchk(`LPD_REG_NEWPWR, 16'h0020);
    rchk(`LPD_REG_STATUS, 16'h0003);
    wr(`LPD_REG_STATUS, 16'h003F);
  endtask
  // unknown id and a bad length, then a quality element with no new start
  task t_badlen;
    peer.send(1'b1, '{8'h7E, 8'h02, 8'hAA, 8'hBB, `LPD_ID_PC, 8'h05, 8'h01, 8'h34, 8'h12, 8'h05, 8'h00,
      `LPD_ID_LQ, 8'h03, 8'h77, 8'hCD, 8'h0B});
    rchk(`LPD_REG_PWR, 16'h0011);
    rchk(`LPD_REG_STATUS, 16'h0014);
    rchk(`LPD_REG_LQ, 16'h0077);
    rchk(`LPD_REG_TXLQ, 16'h0BCD);
    wr(`LPD_REG_STATUS, 16'h003F);
  endtask
  task t_disassoc;
    wr(`LPD_REG_MASK, 16'h0008);
    peer.send(1'b1, '{`LPD_ID_DA, 8'h06, 8'h34, 8'h12, `LPD_REASON_COEX, 8'h21, 8'h43, 8'h00});
    repeat (2) @(posedge core_clk);
    chk(16'(n_rel), 16'h0001);
    chk(16'(n_end), 16'h0001);
    rchk(`LPD_REG_REASON, 16'h0002);
    chk({15'h0000, irq}, 16'h0001);
    wr(`LPD_REG_MASK, 16'h0000);
    @(negedge core_clk);
    chk({15'h0000, irq}, 16'h0000);
    wr(`LPD_REG_MASK, 16'h0008);
    wr(`LPD_REG_STATUS, 16'h0008);
    @(negedge core_clk);
    chk({15'h0000, irq}, 16'h0000);
    peer.send(1'b1, '{`LPD_ID_DA, 8'h03, 8'h21, 8'h43, 8'h00, `LPD_ID_DA, 8'h03, 8'h34, 8'h12, 8'h00});
    repeat (2) @(posedge core_clk);
    chk(16'(n_rel), 16'h0002);
    rchk(`LPD_REG_REASON, 16'h0000);
    wr(`LPD_REG_STATUS, 16'h003F);
  endtask
  task t_build;
    wr(`LPD_REG_CTRL, 16'h2A00);
    wr(`LPD_REG_TXLQ, 16'h0BCD);
    txchk('{`LPD_ID_LQ, 8'h03, 8'h00, 8'hCD, 8'h0B});
    wr(`LPD_REG_TXPC, 16'h1234);
    txchk('{`LPD_ID_PC, 8'h04, 8'h01, 8'h34, 8'h12, 8'h2A});
    wr(`LPD_REG_TXDA, 16'h5678);
    txchk('{`LPD_ID_DA, 8'h03, 8'h78, 8'h56, 8'h00});
    slow <= 1'b1;
    wr(`LPD_REG_CTRL, 16'hC802);
    wr(`LPD_REG_TXPC, 16'hFFFF);
    txchk('{`LPD_ID_PC, 8'h04, 8'h01, 8'hFF, 8'hFF, 8'h63});
    wr(`LPD_REG_TXDA, 16'h1111);
    txchk('{`LPD_ID_DA, 8'h03, 8'h11, 8'h11, 8'h02});
    slow <= 1'b0;
    rchk(`LPD_REG_STATUS, 16'h0020);
  endtask
  task final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog: the tests need a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors++;
    $display("mismatch t=%0t watchdog", $time);
    final_report;
  end
  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    slow = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_power;
    t_badlen;
    t_disassoc;
    t_build;
    final_report;
  end
endmodule
`default_nettype wire
